// ---- gic_ctrl.sv ----
// grouped interrupt, wake-up and return stack controller
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/10ps
module gic_ctrl
  import gic_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              reset_i,
  input  wire gic_bus_req_t      bus_i,
  output logic [DATA_W-1:0]      rdata_o,
  input  wire gic_core_req_t     core_i,
  input  wire logic              low_supply_i,
  input  wire logic              eeprom_done_i,
  input  wire logic              sleep_i,
  output logic                   vector_req_o,
  output logic [PC_W-1:0]        vector_addr_o,
  output logic [PC_W-1:0]        return_addr_o,
  output logic                   return_valid_o,
  output logic                   stack_full_o,
  output logic                   wake_o,
  output logic                   irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // state

  gic_state_t s_q;
  gic_state_t s_d;

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    gic_flags_t flags_w;
    gic_flags_t rise;
    gic_ev_t    ev_set;
    logic       taken;
    logic       src_low;
    logic       src_mem;
    logic       full;
    logic       empty;
    logic [IDX_W-1:0] top;
    flags_w = '0;
    rise    = '0;
    ev_set  = '0;
    taken   = 1'b0;
    src_low = 1'b0;
    src_mem = 1'b0;
    full    = 1'b0;
    empty   = 1'b0;
    top     = '0;
    s_d     = s_q;

    full  = (s_q.sp == SP_FULL);
    empty = (s_q.sp == '0);
    top   = IDX_W'(s_q.sp - SP_ONE);

    // software writes; flags may be preset high to mask wake-up sources
    if (bus_i.wr && bus_i.addr == OFF_CTRL) begin
      s_d.ctrl = bus_i.wdata[$bits(gic_ctrl_t)-1:0];
    end else if (bus_i.wr && bus_i.addr == OFF_IRQEN) begin
      s_d.ev_enable = bus_i.wdata[$bits(gic_ev_t)-1:0];
    end
    flags_w = s_q.flags;
    if (bus_i.wr && bus_i.addr == OFF_FLAGS) begin
      flags_w = bus_i.wdata[$bits(gic_flags_t)-1:0];
    end

    // service: the core has taken the vector the block offered
    taken = core_i.vector_ack && s_q.vector_req && !full;
    if (taken) begin
      s_d.ctrl.global_irq_enable = 1'b0;
      flags_w.group_irq_flag     = 1'b0;
    end

    // hardware sets come last so an event beats a same-cycle clear
    s_d.flags = flags_w;
    if (low_supply_i) begin
      s_d.flags.low_supply_flag = 1'b1;
    end
    if (eeprom_done_i) begin
      s_d.flags.eeprom_done_flag = 1'b1;
    end

    // group flag follows a source rising under its own enable, low supply also under grouped_source_enable
    src_low = s_d.flags.low_supply_flag && !s_q.flags.low_supply_flag
              && s_q.ctrl.low_supply_irq_enable
              && s_q.ctrl.grouped_source_enable;
    src_mem = s_d.flags.eeprom_done_flag && !s_q.flags.eeprom_done_flag
              && s_q.ctrl.eeprom_done_irq_enable;
    if (src_low || src_mem) begin
      s_d.flags.group_irq_flag = 1'b1;
    end

    // wake-up on any flag going 0 to 1, enables play no part
    rise   = s_d.flags & ~s_q.flags;
    s_d.wake = sleep_i && (|rise);

    // return stack: only the program counter is kept
    s_d.return_valid = 1'b0;
    if (taken || (core_i.call && !full)) begin
      s_d.stack[s_q.sp[IDX_W-1:0]] = core_i.pc;
      s_d.sp = s_q.sp + SP_ONE;
    end else if (core_i.call && full) begin
      // an overflowing call is dropped, the caller's return is lost
      ev_set.stack_overflow = 1'b1;
    end else if ((core_i.plain_subroutine_exit ||
                  core_i.interrupt_exit_instruction) && !empty) begin
      s_d.return_addr  = s_q.stack[top];
      s_d.return_valid = 1'b1;
      s_d.sp           = s_q.sp - SP_ONE;
    end
    if (core_i.interrupt_exit_instruction && !empty && !taken &&
        !core_i.call) begin
      s_d.ctrl.global_irq_enable = 1'b1;
    end

    // full flag and vector address kept in flops so the pins carry no logic
    s_d.stack_full  = (s_d.sp == SP_FULL);
    s_d.vector_addr = GROUP_VECTOR;

    // offer the group vector while enabled, pending and stack has room
    s_d.vector_req = s_d.ctrl.global_irq_enable
                     && s_d.ctrl.group_irq_enable
                     && s_d.flags.group_irq_flag
                     && !s_d.stack_full;

    // sticky event status, set wins over a same-cycle clear
    ev_set.vector_taken = taken;
    ev_set.wake         = s_d.wake;
    if (bus_i.wr && bus_i.addr == OFF_CLEAR) begin
      s_d.ev_status = s_q.ev_status
                      & ~bus_i.wdata[$bits(gic_ev_t)-1:0];
    end
    s_d.ev_status = s_d.ev_status | ev_set;
    s_d.irq       = |(s_d.ev_status & s_d.ev_enable);

    // read port, data valid in the cycle after the strobe
    s_d.rdata = '0;
    if (bus_i.rd) begin
      if (bus_i.addr == OFF_CTRL) begin
        s_d.rdata = DATA_W'(s_q.ctrl);
      end else if (bus_i.addr == OFF_FLAGS) begin
        s_d.rdata = DATA_W'(s_q.flags);
      end else if (bus_i.addr == OFF_STACK) begin
        s_d.rdata = DATA_W'({full, s_q.sp});
      end else if (bus_i.addr == OFF_STATUS) begin
        s_d.rdata = DATA_W'(s_q.ev_status);
      end else if (bus_i.addr == OFF_IRQEN) begin
        s_d.rdata = DATA_W'(s_q.ev_enable);
      end else begin
        s_d.rdata = '0; // clear register and holes read zero
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      s_q           <= '0;
      s_q.ctrl      <= CTRL_RESET;
      s_q.flags     <= FLAGS_RESET;
    end else begin
      s_q           <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all taken from flip-flops

  assign rdata_o        = s_q.rdata;
  assign vector_req_o   = s_q.vector_req;
  // vector address reads zero in reset, the group vector after it
  assign vector_addr_o  = s_q.vector_addr;
  assign return_addr_o  = s_q.return_addr;
  assign return_valid_o = s_q.return_valid;
  assign stack_full_o   = s_q.stack_full;
  assign wake_o         = s_q.wake;
  assign irq_o          = s_q.irq;

endmodule : gic_ctrl

// ---- gic_pkg.sv ----
// constants, register map and carrier types of the grouped interrupt block
// What this block does
// - low supply report from the detector sets the low supply flag
// - low supply vectors only with global, source and group enables set
// - low supply vector call is made only while the stack has room
// - servicing clears global enable and group flag; source flag stays
// - every finished memory erase or write sets the memory done flag
// - memory done vectors only with all three enables and stack not full
// - memory servicing clears global enable and group flag; source stays
// - in sleep or idle any request flag rising wakes the device
// - wake-up ignores every enable bit
// - a set flag stays set until serviced or cleared by software
// - vectoring pushes only the program counter onto the stack
// - interrupt exit with the stack not empty pops the return address and sets global enable
// - plain subroutine exit pops without touching the global enable
package gic_pkg;

  localparam int        ADDR_W      = 8;
  localparam int        DATA_W      = 8;
  localparam int        PC_W        = 12;
  localparam int        STACK_DEPTH = 8;
  localparam int        IDX_W       = $clog2(STACK_DEPTH);
  localparam int        SP_W        = IDX_W + 1;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_FLAGS  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STACK  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_CLEAR  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQEN  = 8'h14;

  localparam logic [PC_W-1:0]   GROUP_VECTOR = 12'h00c;
  localparam logic [SP_W-1:0]   SP_FULL      = SP_W'(STACK_DEPTH);
  localparam logic [SP_W-1:0]   SP_ONE       = SP_W'(1'b1);

  // control register, bit 4 downward
  typedef struct packed {
    logic eeprom_done_irq_enable;
    logic low_supply_irq_enable;
    logic grouped_source_enable;
    logic group_irq_enable;
    logic global_irq_enable;
  } gic_ctrl_t;

  // request flags, bit 2 downward
  typedef struct packed {
    logic group_irq_flag;
    logic eeprom_done_flag;
    logic low_supply_flag;
  } gic_flags_t;

  // sticky event bits, bit 2 downward
  typedef struct packed {
    logic stack_overflow;
    logic wake;
    logic vector_taken;
  } gic_ev_t;

  localparam gic_ctrl_t  CTRL_RESET  = '0;
  localparam gic_flags_t FLAGS_RESET = '0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } gic_bus_req_t;

  typedef struct packed {
    logic            vector_ack;
    logic            call;
    logic            plain_subroutine_exit;
    logic            interrupt_exit_instruction;
    logic [PC_W-1:0] pc;
  } gic_core_req_t;

  typedef struct packed {
    gic_ctrl_t                       ctrl;
    gic_flags_t                      flags;
    gic_ev_t                         ev_status;
    gic_ev_t                         ev_enable;
    logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
    logic [SP_W-1:0]                 sp;
    logic [DATA_W-1:0]               rdata;
    logic                            vector_req;
    logic                            wake;
    logic                            irq;
    logic [PC_W-1:0]                 return_addr;
    logic                            return_valid;
    logic                            stack_full;
    logic [PC_W-1:0]                 vector_addr;
  } gic_state_t;

endpackage : gic_pkg

// ---- gic_ctrl_checker.sv ----
// port assertions for the grouped interrupt block
`timescale 1ns/10ps
module gic_chk
  import gic_pkg::*;
(
  input wire logic          ref_clk_i,
  input wire logic          reset_i,
  input wire gic_bus_req_t  bus_i,
  input wire gic_core_req_t core_i,
  input wire logic          low_supply_i,
  input wire logic          eeprom_done_i,
  input wire logic          sleep_i,
  input wire logic          vector_req_o,
  input wire logic [PC_W-1:0] vector_addr_o,
  input wire logic          return_valid_o,
  input wire logic          stack_full_o,
  input wire logic          wake_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // taken vector, pops, and every cause that can raise a flag
  wire tk = vector_req_o & core_i.vector_ack & ~stack_full_o;
  wire ex = core_i.interrupt_exit_instruction | core_i.plain_subroutine_exit;
  wire sr = low_supply_i | eeprom_done_i | bus_i.wr;
  ////////////////////////////////////////
  AST_VADDR: assert property (
    vector_req_o |-> vector_addr_o == GROUP_VECTOR) else $error("addr");
  AST_TAKE: assert property (
    tk |=> !vector_req_o) else $error("request kept");
  AST_GIE_LOW: assert property (
    tk ##1 !(ex | bus_i.wr) |=> !vector_req_o) else $error("reenabled");
  AST_FULL: assert property (
    stack_full_o && core_i.vector_ack |=> stack_full_o) else $error("full");
  AST_FULL_NOREQ: assert property (
    stack_full_o |-> !vector_req_o) else $error("request when full");
  AST_IDLE_ACK: assert property (
    !vector_req_o && core_i.vector_ack |=> $stable(stack_full_o))
    else $error("push");
  AST_POP: assert property (
    return_valid_o |-> $past(ex)) else $error("pop");
  AST_WAKE: assert property (
    wake_o |-> $past(sleep_i)) else $error("wake awake");
  AST_WAKE_SRC: assert property (
    wake_o |-> $past(sr)) else $error("wake cause");
  // main scenarios reached
  cover property (tk);
  cover property (wake_o);
  cover property (stack_full_o);
  cover property (return_valid_o);
endmodule : gic_chk
bind gic_ctrl gic_chk u_chk (
  .ref_clk_i      (ref_clk_i),
  .reset_i        (reset_i),
  .bus_i          (bus_i),
  .core_i         (core_i),
  .low_supply_i   (low_supply_i),
  .eeprom_done_i  (eeprom_done_i),
  .sleep_i        (sleep_i),
  .vector_req_o   (vector_req_o),
  .vector_addr_o  (vector_addr_o),
  .return_valid_o (return_valid_o),
  .stack_full_o   (stack_full_o),
  .wake_o         (wake_o)
);

// ---- gic_core.sv ----
// core model: takes the group vector, runs a routine, then returns
`timescale 1ns/10ps
module gic_core
  import gic_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic        req_i,
  input  wire logic [2:0]  mode_i,
  input  wire logic [11:0] pc_i,
  output gic_core_req_t    core_o
);
  logic [3:0] cnt_q = '0;
  logic       busy_q = '0;
  // take the vector, run the routine, then leave it once
  wire take = !reset_i && !busy_q && req_i && mode_i[0];
  wire done = !reset_i && busy_q && (cnt_q == 4'h0);
  wire cl   = !reset_i && !busy_q && !take && mode_i[2];
  // ack and exit strobes last one cycle, call repeats every cycle; mode: 0 ack, 1 interrupt exit, 2 calls
  always @(posedge ref_clk_i) begin
    core_o.pc <= pc_i;
    core_o.vector_ack <= take;
    core_o.interrupt_exit_instruction <= done && mode_i[1];
    core_o.plain_subroutine_exit <= done && !mode_i[1];
    core_o.call <= cl;
    if (reset_i) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
    end else if (take) begin
      busy_q <= 1'b1;
      cnt_q <= 4'hc;
    end else if (cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
    else if (busy_q)
      busy_q <= 1'b0;
  end
endmodule : gic_core

// ---- tb.sv ----
// self-checking bench for the grouped interrupt block
`timescale 1ns/10ps
module tb;
  import gic_pkg::*;
  logic          ref_clk_i = 1'b0;
  logic          reset_i = 1'b1;
  gic_bus_req_t  bus = '0;
  gic_core_req_t core;
  logic [1:0]    ev = '0;
  logic [2:0]    mode = 3'h3;
  logic          sleep = 1'b0;
  logic [11:0]   va, ra;
  logic [7:0]    rdata;
  logic          vreq, rvld, full, wake, irq;
  int            n_errors = 0;
  int            checks = 0;
  gic_ctrl DUT (.ref_clk_i, .reset_i, .bus_i(bus), .rdata_o(rdata),
    .core_i(core), .low_supply_i(ev[0]), .eeprom_done_i(ev[1]),
    .sleep_i(sleep), .vector_req_o(vreq), .vector_addr_o(va),
    .return_addr_o(ra), .return_valid_o(rvld), .stack_full_o(full),
    .wake_o(wake), .irq_o(irq));
  gic_core u_core (.ref_clk_i, .reset_i, .req_i(vreq), .mode_i(mode),
    .pc_i(12'h5a3), .core_o(core));
  // 100 MHz clock
  always #5 ref_clk_i = ~ref_clk_i;
  ////////////////////////////////////////
  task automatic end_of_test();
    if (n_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic chk(input string n, input logic [11:0] e, g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : cyc
  // r high reads and compares d, else writes d; data taken at next edge
  task automatic acc(input logic r, input logic [7:0] a, d);
    @(posedge ref_clk_i);
    bus <= '{a, d, !r, r};
    @(posedge ref_clk_i);
    bus <= '0;
    @(posedge ref_clk_i);
    if (r)
      chk("rdata", {4'h0, d}, {4'h0, rdata});
  endtask : acc
  // one-cycle event: 1 low supply, 2 memory done
  task automatic pulse(input logic [1:0] s);
    @(posedge ref_clk_i);
    ev <= s;
    @(posedge ref_clk_i);
    ev <= '0;
  endtask : pulse
  // bounded wait on full, wake, return or request
  task automatic wait_for(input logic [3:0] m);
    repeat (40) begin
      cyc(1);
      if (({full, wake, rvld, vreq} & m) != 4'h0)
        return;
    end
    n_errors++;
    end_of_test();
  endtask : wait_for
  // main sequence
  initial begin
    repeat (12) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    acc(1'b1, OFF_CLEAR, 8'h00);
    acc(1'b1, 8'h20, 8'h00);
    acc(1'b0, OFF_IRQEN, 8'h01);
    acc(1'b0, OFF_CTRL, 8'h0f);
    pulse(2'h1);
    wait_for(4'h1);
    chk("vaddr", GROUP_VECTOR, va);
    cyc(3);
    acc(1'b1, OFF_CTRL, 8'h0e);
    acc(1'b1, OFF_FLAGS, 8'h01);
    chk("irq", 12'h1, {11'h0, irq});
    wait_for(4'h2);
    chk("raddr", 12'h5a3, ra);
    acc(1'b1, OFF_CTRL, 8'h0f);
    acc(1'b0, OFF_IRQEN, 8'h00);
    cyc(1);
    chk("irq", 12'h0, {11'h0, irq});
    acc(1'b0, OFF_CLEAR, 8'h01);
    acc(1'b1, OFF_STATUS, 8'h00);
    // memory completion, plain return keeps interrupts off
    mode <= 3'h1;
    acc(1'b0, OFF_FLAGS, 8'h00);
    acc(1'b0, OFF_CTRL, 8'h13);
    pulse(2'h2);
    wait_for(4'h1);
    wait_for(4'h2);
    acc(1'b1, OFF_CTRL, 8'h12);
    acc(1'b1, OFF_FLAGS, 8'h02);
    // enables off: flag still sets and stays, no request
    acc(1'b0, OFF_CTRL, 8'h00);
    pulse(2'h1);
    cyc(3);
    chk("vreq", 12'h0, {11'h0, vreq});
    acc(1'b1, OFF_FLAGS, 8'h03);
    // sleep: a rising flag wakes, a preset one cannot
    acc(1'b0, OFF_FLAGS, 8'h01);
    sleep <= 1'b1;
    pulse(2'h2);
    wait_for(4'h4);
    pulse(2'h1);
    cyc(1);
    chk("wake", 12'h0, {11'h0, wake});
    // fill the stack; a vector is then refused
    sleep <= 1'b0;
    mode <= 3'h4;
    wait_for(4'h8);
    mode <= 3'h1;
    acc(1'b1, OFF_STACK, 8'h18);
    acc(1'b1, OFF_STATUS, 8'h07);
    acc(1'b0, OFF_FLAGS, 8'h00);
    acc(1'b0, OFF_CTRL, 8'h0f);
    pulse(2'h1);
    cyc(3);
    chk("vreq", 12'h0, {11'h0, vreq});
    acc(1'b1, OFF_CTRL, 8'h0f);
    acc(1'b1, OFF_FLAGS, 8'h05);
    end_of_test();
  end
endmodule : tb
